// file: verilog/iit_issue_ctl.sv
// Issue and result latency control for the in-order core pipeline
`timescale 1ns/10ps
module iit_issue_ctl
   import iit_pkg::*;
(
   input  wire logic                 clk_sys,      // Core clock, 20 MHz
   input  wire logic                 rst_n,        // Async reset, low
   input  wire logic                 instr_valid,  // Decoded instruction offered
   input  wire iit_class_t           instr_class,  // Instruction class
   input  wire logic                 compressed,   // 16-bit encoding
   input  wire logic                 h_bit,        // Long branch half select
   input  wire logic                 mode_change,  // Status write alters mode
   input  wire logic [IIT_REG_W-1:0] dst_reg,      // First destination
   input  wire logic                 dst_en,       // Destination written
   input  wire logic [IIT_REG_W-1:0] base_reg,     // Base register
   input  wire logic                 base_wb,      // Base written back
   input  wire logic [IIT_NREG-1:0]  reg_list,     // Multiple transfer list
   input  wire logic [IIT_REG_W-1:0] src_a,        // Source operand a
   input  wire logic                 src_a_en,     // Source a used
   input  wire logic [IIT_REG_W-1:0] src_b,        // Source operand b
   input  wire logic                 src_b_en,     // Source b used
   input  wire logic                 src_b_late,   // b is shift or doubled operand
   input  wire logic                 irq_det,      // Normal request detected
   input  wire logic                 fiq_det,      // Fast request detected
   output logic                      instr_issue,  // Instruction issued this cycle
   output logic                      stall,        // Issue held
   output logic                      irq_take,     // Normal interrupt recognised
   output logic                      fiq_take,     // Fast interrupt recognised
   output logic                      handler_ok    // Soft interrupt handler may start
);
   // ************************************************
   // Decode
   // ************************************************
   iit_sb_if sbi ();

   logic [IIT_CNT_W-1:0] issue_cnt;
   logic [2:0]           swi_cnt;
   logic                 irq_raw;
   logic                 fiq_raw;

   // Branch-high half of a long branch times as plain data
   wire        is_bl_hi = compressed && !h_bit;
   iit_class_t eff_cls;
   assign eff_cls = (instr_class == IIT_CLS_LONG_BRANCH_HI && is_bl_hi) ? IIT_CLS_DATA
                                                                         : instr_class;

   wire [IIT_CNT_W-1:0] list_n;
   assign list_n = IIT_CNT_W'($countones(reg_list));
   wire pc_in_list = reg_list[IIT_PC_REG];

   logic [IIT_CNT_W-1:0] iss_lat;
   logic [IIT_CNT_W-1:0] res_lat;
   logic [IIT_CNT_W-1:0] res_hi;
   logic [IIT_CNT_W-1:0] wb_lat;
   always_comb begin
      iss_lat = IIT_ISS_ONE;
      res_lat = IIT_RES_ONE;
      res_hi  = '0;
      wb_lat  = IIT_RES_WB;
      unique case (eff_cls)
         IIT_CLS_SATURATING:     res_lat = IIT_RES_SAT;
         IIT_CLS_STATUS_READ:    res_lat = IIT_RES_STAT_RD;
         IIT_CLS_STATUS_WRITE: begin
            iss_lat = mode_change ? IIT_ISS_STAT_MODE : IIT_ISS_STAT_WR;
            res_lat = IIT_RES_STAT_WR;
         end
         IIT_CLS_LOAD:           res_lat = IIT_RES_LOAD;
         IIT_CLS_DOUBLE_LOAD: begin
            iss_lat = (dst_reg == IIT_REG_TWELVE) ? IIT_ISS_ONE + 5'h01 : IIT_ISS_ONE;
            res_lat = IIT_RES_LOAD;
            res_hi  = IIT_RES_DLOAD_HI;
            wb_lat  = IIT_RES_DLOAD_WB;
         end
         IIT_CLS_STORE, IIT_CLS_PRELOAD: iss_lat = IIT_ISS_ONE;
         IIT_CLS_DOUBLE_STORE:   iss_lat = IIT_ISS_DSTORE;
         IIT_CLS_LOAD_MULTIPLE: begin
            iss_lat = (pc_in_list ? IIT_ISS_LDM_PC : IIT_ISS_LDM) + list_n;
            res_lat = IIT_RES_LDM;
         end
         IIT_CLS_STORE_MULTIPLE: iss_lat = IIT_ISS_STM + list_n;
         IIT_CLS_SWAP: begin
            iss_lat = IIT_ISS_SWAP;
            res_lat = IIT_RES_SWAP;
         end
         IIT_CLS_SYSCP_READ: begin
            iss_lat = IIT_ISS_SYS_RD;
            res_lat = IIT_RES_SYS_RD;
         end
         IIT_CLS_SYSCP_WRITE:    iss_lat = IIT_ISS_SYS_WR;
         IIT_CLS_DBGCP_READ: begin
            iss_lat = IIT_ISS_DBG;
            res_lat = IIT_RES_DBG_RD;
         end
         IIT_CLS_DBGCP_WRITE, IIT_CLS_DBGCP_STORE: iss_lat = IIT_ISS_DBG;
         IIT_CLS_DBGCP_LOAD:     iss_lat = IIT_ISS_DBG_LOAD;
         IIT_CLS_SOFT_INT:       iss_lat = IIT_ISS_SOFT_INT;
         IIT_CLS_CLZ:            res_lat = IIT_RES_ONE;
         default: begin
            iss_lat = IIT_ISS_ONE;
            res_lat = IIT_RES_ONE;
         end
      endcase
   end

   // ************************************************
   // Interlock
   // ************************************************
   // Late-use operands need one more cycle of the producer
   wire a_hit   = src_a_en && sbi.busy[src_a];
   wire b_hit   = src_b_en && sbi.busy[src_b];
   wire b_late  = src_b_en && src_b_late && sbi.late_shift[src_b];
   wire hazard  = a_hit || b_hit || b_late;
   wire can_go  = instr_valid && (issue_cnt == '0) && !hazard;

   wire writes_dst = dst_en && (res_lat != '0) &&
                     !(eff_cls inside {IIT_CLS_STORE, IIT_CLS_DOUBLE_STORE, IIT_CLS_STORE_MULTIPLE,
                                       IIT_CLS_PRELOAD});

   // A latency of one is already met on the next cycle
   assign sbi.wr_a  = can_go && writes_dst;
   assign sbi.reg_a = dst_reg;
   assign sbi.lat_a = res_lat;
   assign sbi.wr_b  = can_go && (eff_cls == IIT_CLS_DOUBLE_LOAD) && dst_en;
   assign sbi.reg_b = dst_reg + 4'h1;
   assign sbi.lat_b = res_hi;
   assign sbi.wr_c  = can_go && base_wb;
   assign sbi.reg_c = base_reg;
   assign sbi.lat_c = wb_lat;

   iit_scoreboard u_sb (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .sb      (sbi)
   );

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         issue_cnt <= '0;
      end else if (can_go) begin
         issue_cnt <= iss_lat - 5'h01;
      end else if (issue_cnt != '0) begin
         issue_cnt <= issue_cnt - 5'h01;
      end
   end

   // ************************************************
   // Soft interrupt entry timer
   // ************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         swi_cnt <= '0;
      end else if (can_go && eff_cls == IIT_CLS_SOFT_INT) begin
         swi_cnt <= IIT_ISS_SOFT_INT[2:0] - 3'h1;
      end else if (swi_cnt != '0) begin
         swi_cnt <= swi_cnt - 3'h1;
      end
   end

   // ************************************************
   // Interrupt recognition
   // ************************************************
   iit_irq_delay u_irq (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .irq_det  (irq_det),
      .fiq_det  (fiq_det),
      .irq_take (irq_raw),
      .fiq_take (fiq_raw)
   );

   // Output registers; the six-stage delay line plus this register makes the seven-cycle count
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         instr_issue <= 1'b0;
         stall       <= 1'b0;
         irq_take    <= 1'b0;
         fiq_take    <= 1'b0;
         handler_ok  <= 1'b1;
      end else begin
         instr_issue <= can_go;
         stall       <= instr_valid && !can_go;
         irq_take    <= irq_raw;
         fiq_take    <= fiq_raw;
         handler_ok  <= (swi_cnt <= 3'h1) && !(can_go && eff_cls == IIT_CLS_SOFT_INT);
      end
   end
endmodule

// file: verilog/iit_pkg.sv
// Constants and types for the instruction issue timing block
package iit_pkg;

   // ************************************************
   // Widths
   // ************************************************
   localparam int IIT_REG_W = 4;
   localparam int IIT_CNT_W = 5;
   localparam int IIT_NREG  = 16;

   localparam logic [3:0] IIT_PC_REG     = 4'hf;
   localparam logic [3:0] IIT_REG_TWELVE = 4'hc;

   // ************************************************
   // Instruction classes
   // ************************************************
   typedef enum logic [4:0] {
      IIT_CLS_DATA,
      IIT_CLS_SATURATING,
      IIT_CLS_STATUS_READ,
      IIT_CLS_STATUS_WRITE,
      IIT_CLS_LOAD,
      IIT_CLS_DOUBLE_LOAD,
      IIT_CLS_STORE,
      IIT_CLS_DOUBLE_STORE,
      IIT_CLS_PRELOAD,
      IIT_CLS_LOAD_MULTIPLE,
      IIT_CLS_STORE_MULTIPLE,
      IIT_CLS_SWAP,
      IIT_CLS_SYSCP_READ,
      IIT_CLS_SYSCP_WRITE,
      IIT_CLS_DBGCP_READ,
      IIT_CLS_DBGCP_WRITE,
      IIT_CLS_DBGCP_LOAD,
      IIT_CLS_DBGCP_STORE,
      IIT_CLS_SOFT_INT,
      IIT_CLS_CLZ,
      IIT_CLS_LONG_BRANCH_HI
   } iit_class_t;

   // ************************************************
   // Latencies in core cycles
   // ************************************************
   localparam logic [4:0] IIT_ISS_ONE       = 5'h01;
   localparam logic [4:0] IIT_ISS_STAT_WR   = 5'h02;
   localparam logic [4:0] IIT_ISS_STAT_MODE = 5'h06;
   localparam logic [4:0] IIT_ISS_DSTORE    = 5'h02;
   localparam logic [4:0] IIT_ISS_LDM_PC    = 5'h07;
   localparam logic [4:0] IIT_ISS_LDM       = 5'h02;
   localparam logic [4:0] IIT_ISS_STM       = 5'h02;
   localparam logic [4:0] IIT_ISS_SWAP      = 5'h05;
   localparam logic [4:0] IIT_ISS_SYS_RD    = 5'h04;
   localparam logic [4:0] IIT_ISS_SYS_WR    = 5'h02;
   localparam logic [4:0] IIT_ISS_DBG       = 5'h07;
   localparam logic [4:0] IIT_ISS_DBG_LOAD  = 5'h0a;
   localparam logic [4:0] IIT_ISS_SOFT_INT  = 5'h06;

   localparam logic [4:0] IIT_RES_SAT      = 5'h02;
   localparam logic [4:0] IIT_RES_STAT_RD  = 5'h02;
   localparam logic [4:0] IIT_RES_STAT_WR  = 5'h01;
   localparam logic [4:0] IIT_RES_LOAD     = 5'h03;
   localparam logic [4:0] IIT_RES_DLOAD_HI = 5'h04;
   localparam logic [4:0] IIT_RES_DLOAD_WB = 5'h02;
   localparam logic [4:0] IIT_RES_WB       = 5'h01;
   localparam logic [4:0] IIT_RES_LDM      = 5'h03;
   localparam logic [4:0] IIT_RES_SWAP     = 5'h05;
   localparam logic [4:0] IIT_RES_SYS_RD   = 5'h04;
   localparam logic [4:0] IIT_RES_DBG_RD   = 5'h07;
   localparam logic [4:0] IIT_RES_ONE      = 5'h01;
   localparam logic [4:0] IIT_RES_EXTRA    = 5'h01;

   localparam logic [2:0] IIT_IRQ_DELAY = 3'h6;

endpackage

// file: verilog/iit_sb_if.sv
// Scoreboard write and query signals shared inside the timing block
`timescale 1ns/10ps
interface iit_sb_if;
   import iit_pkg::*;
   logic                 wr_a;
   logic [IIT_REG_W-1:0] reg_a;
   logic [IIT_CNT_W-1:0] lat_a;
   logic                 wr_b;
   logic [IIT_REG_W-1:0] reg_b;
   logic [IIT_CNT_W-1:0] lat_b;
   logic                 wr_c;
   logic [IIT_REG_W-1:0] reg_c;
   logic [IIT_CNT_W-1:0] lat_c;
   logic [IIT_NREG-1:0]  busy;
   logic [IIT_NREG-1:0]  late_shift;

   modport ctl (output wr_a, reg_a, lat_a, wr_b, reg_b, lat_b, wr_c, reg_c, lat_c,
                input busy, late_shift);
   modport sb  (input wr_a, reg_a, lat_a, wr_b, reg_b, lat_b, wr_c, reg_c, lat_c,
                output busy, late_shift);
endinterface

// file: verilog/iit_scoreboard.sv
// Per-register result countdown used by the issue interlock
`timescale 1ns/10ps
module iit_scoreboard
   import iit_pkg::*;
(
   input wire logic clk_sys,     // Core clock
   input wire logic rst_n,       // Async reset, low
   iit_sb_if.sb     sb           // Writes and busy view
);
   logic [IIT_CNT_W-1:0] cnt [IIT_NREG];

   genvar g;
   generate
      for (g = 0; g < IIT_NREG; g++) begin : g_reg
         wire              hit_a = sb.wr_a && (sb.reg_a == IIT_REG_W'(g));
         wire              hit_b = sb.wr_b && (sb.reg_b == IIT_REG_W'(g));
         wire              hit_c = sb.wr_c && (sb.reg_c == IIT_REG_W'(g));
         wire [IIT_CNT_W-1:0] dec = (cnt[g] != '0) ? cnt[g] - 5'h01 : '0;
         // Latest writer wins: c over b over a
         wire [IIT_CNT_W-1:0] next_cnt = hit_c ? sb.lat_c - 5'h01 :
                                         hit_b ? sb.lat_b - 5'h01 :
                                         hit_a ? sb.lat_a - 5'h01 : dec;
         logic                recent;
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               cnt[g] <= '0;
               recent <= 1'b0;
            end else begin
               cnt[g] <= next_cnt;
               // Written or still counting last cycle, so a latency of one also gets its extra cycle
               recent <= (cnt[g] != '0) || hit_a || hit_b || hit_c;
            end
         end
         assign sb.busy[g]       = (cnt[g] != '0);
         // Shift or doubled operand: one cycle more
         assign sb.late_shift[g] = recent;
      end
   endgenerate
endmodule

// file: verilog/iit_irq_delay.sv
// Interrupt recognition delay line
`timescale 1ns/10ps
module iit_irq_delay
   import iit_pkg::*;
(
   input  wire logic clk_sys,    // Core clock
   input  wire logic rst_n,      // Async reset, low
   input  wire logic irq_det,    // Controller saw normal request
   input  wire logic fiq_det,    // Controller saw fast request
   output logic      irq_take,   // Normal request recognised
   output logic      fiq_take    // Fast request recognised
);
   logic [IIT_IRQ_DELAY-1:0] irq_pipe;
   logic [IIT_IRQ_DELAY-1:0] fiq_pipe;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_pipe <= '0;
         fiq_pipe <= '0;
      end else begin
         irq_pipe <= {irq_pipe[IIT_IRQ_DELAY-2:0], irq_det};
         fiq_pipe <= {fiq_pipe[IIT_IRQ_DELAY-2:0], fiq_det};
      end
   end
   assign irq_take = irq_pipe[IIT_IRQ_DELAY-1];
   assign fiq_take = fiq_pipe[IIT_IRQ_DELAY-1];
endmodule

// file: testbench/iit_checker.sv
// Timing assertions for the instruction issue control
`timescale 1ns/10ps
module iit_checker
   import iit_pkg::*;
(
   input wire logic       clk_sys,     // Core clock
   input wire logic       rst_n,       // Async reset, low
   input wire logic       instr_valid, // Offered
   input wire iit_class_t instr_class, // Class
   input wire logic       mode_change, // Mode write
   input wire logic       irq_det,     // Normal detect
   input wire logic       fiq_det,     // Fast detect
   input wire logic       instr_issue, // Issued
   input wire logic       stall,       // Held
   input wire logic       irq_take,    // Normal taken
   input wire logic       fiq_take,    // Fast taken
   input wire logic       handler_ok   // Handler allowed
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // Class behind this pulse was sampled one edge earlier
   sequence iss_of(iit_class_t c);
      instr_issue && $past(instr_class) == c;
   endsequence

   irq_delay_a: assert property (irq_take == $past(irq_det, 7))
      else $error("Normal take not seven edges after detect");
   fiq_delay_a: assert property (fiq_take == $past(fiq_det, 7))
      else $error("Fast take not seven edges after detect");
   stall_cause_a: assert property (stall |-> $past(instr_valid) && !instr_issue)
      else $error("Stall without a held offer");
   issue_cause_a: assert property (instr_issue |-> $past(instr_valid))
      else $error("Issue without an offer");
   swap_gap_a: assert property (iss_of(IIT_CLS_SWAP) |=> !instr_issue [*4])
      else $error("Swap issue gap short");
   mode_gap_a: assert property (iss_of(IIT_CLS_STATUS_WRITE) ##0 $past(mode_change) |=> !instr_issue [*5])
      else $error("Mode write issue gap short");
   sysrd_gap_a: assert property (iss_of(IIT_CLS_SYSCP_READ) |=> !instr_issue [*3])
      else $error("System read issue gap short");
   dbg_load_a: assert property (iss_of(IIT_CLS_DBGCP_LOAD) |=> !instr_issue [*8] ##1 !instr_issue)
      else $error("Debug load issue gap short");
   dstore_gap_a: assert property (iss_of(IIT_CLS_DOUBLE_STORE) |=> !instr_issue)
      else $error("Double store issue gap short");
   handler_wait_a: assert property (iss_of(IIT_CLS_SOFT_INT) |=> !handler_ok [*4] ##[1:8] handler_ok)
      else $error("Handler entry timing wrong");

   cover property (iss_of(IIT_CLS_LOAD_MULTIPLE));
   cover property (stall);
   cover property (fiq_take);
endmodule

bind iit_issue_ctl iit_checker chk_u (.clk_sys, .rst_n, .instr_valid, .instr_class, .mode_change, .irq_det,
   .fiq_det, .instr_issue, .stall, .irq_take, .fiq_take, .handler_ok);

// file: testbench/iit_irq_src.sv
// Interrupt controller stand-in giving random detect pulses, redrawn each falling edge
`timescale 1ns/10ps
module iit_irq_src (
   input  wire logic clk_sys, // Core clock
   input  wire logic enable,  // Start after reset
   output logic      irq_det, // Normal request seen
   output logic      fiq_det  // Fast request seen
);
   int seed = 99795;

   initial begin
      irq_det = 1'b0;
      fiq_det = 1'b0;
      forever begin
         @(negedge clk_sys);
         irq_det = enable && ($random(seed) % 6 == 0);
         fiq_det = enable && ($random(seed) % 6 == 0);
      end
   end
endmodule

// file: testbench/tb_instruction_issue_timing.sv
// Self-checking bench for the instruction issue control
`timescale 1ns/10ps
module tb_instruction_issue_timing;
   import iit_pkg::*;

   logic       clk_sys, rst_n, instr_valid, compressed, h_bit, mode_change, irq_en;
   logic       dst_en, base_wb, src_a_en, src_b_en, src_b_late;
   logic       irq_det, fiq_det, instr_issue, stall, irq_take, fiq_take, handler_ok;
   iit_class_t instr_class;
   logic [3:0] dst_reg, base_reg, src_a, src_b;
   logic [15:0] reg_list;
   logic [6:0] irq_h, fiq_h;
   int         errors, checks, seed, cyc;

   iit_issue_ctl dut_u (.clk_sys, .rst_n, .instr_valid, .instr_class, .compressed, .h_bit, .mode_change,
      .dst_reg, .dst_en, .base_reg, .base_wb, .reg_list, .src_a, .src_a_en, .src_b, .src_b_en, .src_b_late,
      .irq_det, .fiq_det, .instr_issue, .stall, .irq_take, .fiq_take, .handler_ok);
   iit_irq_src irq_u (.clk_sys, .enable(irq_en), .irq_det, .fiq_det);

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         cyc   <= 0;
         irq_h <= '0;
         fiq_h <= '0;
      end else begin
         cyc   <= cyc + 1;
         irq_h <= {irq_h[5:0], irq_det};
         fiq_h <= {fiq_h[5:0], fiq_det};
      end
   end

   always @(negedge clk_sys) begin
      if (rst_n) begin
         checks++;
         if (irq_take !== irq_h[6] || fiq_take !== fiq_h[6]) begin
            errors++;
            $display("ERROR take expected %b%b seen %b%b", irq_h[6], fiq_h[6], irq_take, fiq_take);
         end
      end
   end

   // ****************************************
   // Expectations
   // ****************************************
   function automatic int iss_lat(iit_class_t c, logic m, logic [3:0] d, logic [15:0] l);
      case (c)
         IIT_CLS_STATUS_WRITE: return m ? 6 : 2;
         IIT_CLS_DOUBLE_LOAD: return (d == 4'hc) ? 2 : 1;
         IIT_CLS_DOUBLE_STORE, IIT_CLS_SYSCP_WRITE: return 2;
         IIT_CLS_LOAD_MULTIPLE: return (l[15] ? 7 : 2) + $countones(l);
         IIT_CLS_STORE_MULTIPLE: return 2 + $countones(l);
         IIT_CLS_SWAP: return 5;
         IIT_CLS_SYSCP_READ: return 4;
         IIT_CLS_DBGCP_LOAD: return 10;
         IIT_CLS_DBGCP_READ, IIT_CLS_DBGCP_WRITE, IIT_CLS_DBGCP_STORE: return 7;
         IIT_CLS_SOFT_INT: return 6;
         default: return 1;
      endcase
   endfunction

   function automatic int res_lat(iit_class_t c, int dep);
      if (dep == 3) return (c == IIT_CLS_DOUBLE_LOAD) ? 2 : 1;
      if (dep == 2) return 4;
      case (c)
         IIT_CLS_SATURATING, IIT_CLS_STATUS_READ: return 2;
         IIT_CLS_LOAD, IIT_CLS_DOUBLE_LOAD: return 3;
         IIT_CLS_SWAP: return 5;
         IIT_CLS_SYSCP_READ: return 4;
         IIT_CLS_DBGCP_READ: return 7;
         default: return 1;
      endcase
   endfunction

   function automatic logic has_res(iit_class_t c);
      return c inside {IIT_CLS_DATA, IIT_CLS_SATURATING, IIT_CLS_STATUS_READ, IIT_CLS_LOAD, IIT_CLS_DOUBLE_LOAD,
         IIT_CLS_SWAP, IIT_CLS_SYSCP_READ, IIT_CLS_DBGCP_READ, IIT_CLS_CLZ, IIT_CLS_LONG_BRANCH_HI};
   endfunction

   function automatic logic has_base(iit_class_t c);
      return c inside {IIT_CLS_LOAD, IIT_CLS_DOUBLE_LOAD, IIT_CLS_STORE, IIT_CLS_DOUBLE_STORE,
         IIT_CLS_LOAD_MULTIPLE, IIT_CLS_STORE_MULTIPLE};
   endfunction

   task automatic check(string what, int exp, int got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic finish_test();
      if (errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Offer is held until the issue pulse is seen at a falling edge
   task automatic wait_issue(output int t, output int s);
      int n;
      n = 0;
      s = 0;
      do begin
         @(negedge clk_sys);
         n++;
         if (stall === 1'b1) s++;
      end while (instr_issue !== 1'b1 && n < 40);
      if (n >= 40) check("issue wait", 0, 1);
      t = cyc;
   endtask

   // Producer then a data op: independent, on its result, second word or base
   task automatic run_pair(iit_class_t c, logic m, logic [3:0] d, logic [15:0] l, int dep, logic lt);
      int t0, t1, e, s;
      logic [3:0] b;
      b = 4'((d + 5) % 13);
      if (dep == 2 && c != IIT_CLS_DOUBLE_LOAD) dep = 1;
      if (dep == 1 && !has_res(c)) dep = 0;
      if (dep == 3 && !has_base(c)) dep = 0;
      lt = lt && dep != 0;
      instr_valid = 1'b1;
      instr_class = c;
      mode_change = m;
      dst_reg = d;
      dst_en = has_res(c);
      base_reg = b;
      base_wb = has_base(c);
      reg_list = l & ~(16'h0001 << b);
      compressed = (c == IIT_CLS_LONG_BRANCH_HI) | 1'($random(seed));
      h_bit = (c != IIT_CLS_LONG_BRANCH_HI) & 1'($random(seed));
      e = iss_lat(c, m, d, reg_list);
      if (dep != 0 && res_lat(c, dep) + lt > e) e = res_lat(c, dep) + lt;
      wait_issue(t0, s);
      check("producer stall", 0, s);
      instr_class = IIT_CLS_DATA;
      mode_change = 1'b0;
      dst_en = 1'b0;
      base_wb = 1'b0;
      reg_list = 16'h0000;
      h_bit = 1'b1;
      src_a = (dep == 0) ? 4'he : (dep == 2) ? d + 4'h1 : (dep == 3) ? b : d;
      src_b = src_a;
      src_a_en = !lt;
      src_b_en = lt;
      src_b_late = lt;
      wait_issue(t1, s);
      check("issue gap", e, t1 - t0);
      check("stall cycles", e - 1, s);
      instr_valid = 1'b0;
      src_a_en = 1'b0;
      src_b_en = 1'b0;
      src_b_late = 1'b0;
      repeat (8) @(negedge clk_sys);
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      finish_test();
   end

   initial begin
      int i, k;
      seed = 99795;
      {errors, checks} = '0;
      {irq_en, rst_n, instr_valid, compressed, mode_change} = '0;
      {dst_reg, dst_en, base_reg, base_wb, reg_list, src_a, src_a_en, src_b, src_b_en, src_b_late} = '0;
      instr_class = IIT_CLS_DATA;
      h_bit = 1'b1;
      repeat (4) @(negedge clk_sys);
      rst_n = 1'b1;
      irq_en = 1'b1;
      @(negedge clk_sys);
      for (i = 0; i < 21; i++) begin
         for (k = 0; k < 4; k++) begin
            run_pair(iit_class_t'(i), k[0], 4'($unsigned($random(seed)) % 13), 16'($random(seed)), k,
               1'($random(seed)));
         end
      end
      run_pair(IIT_CLS_DOUBLE_LOAD, 1'b0, 4'hc, 16'h0000, 2, 1'b1);
      run_pair(IIT_CLS_LOAD_MULTIPLE, 1'b0, 4'h0, 16'hffff, 0, 1'b0);
      run_pair(IIT_CLS_LOAD_MULTIPLE, 1'b0, 4'h0, 16'h0002, 3, 1'b0);
      run_pair(IIT_CLS_STORE_MULTIPLE, 1'b0, 4'h0, 16'h0001, 3, 1'b1);
      for (i = 0; i < 40; i++) begin
         run_pair(iit_class_t'($unsigned($random(seed)) % 21), 1'($random(seed)),
            4'($unsigned($random(seed)) % 13), 16'($random(seed)), $unsigned($random(seed)) % 4,
            1'($random(seed)));
      end
      finish_test();
   end
endmodule
